// ==== smb_far_agent.sv ====
`timescale 1ns/1ps
module smb_far_agent (
  // link clock
  input wire logic link_clk,
  // device pin enables
  input wire logic scl_oe,
  input wire logic sda_oe,
  // resolved bus levels
  output logic bus_clock_line,
  output logic bus_data_line
);
  logic scl_pull = 1'h0;
  logic sda_pull = 1'h0;

  // pull-ups: a line nobody pulls reads high
  assign bus_clock_line = ~(scl_oe | scl_pull);
  assign bus_data_line = ~(sda_oe | sda_pull);

  // set both lines (1 = release) and hold them n link cycles
  task automatic lines(input logic c, input logic d, input int n);
    @(negedge link_clk);
    scl_pull = ~c;
    sda_pull = ~d;
    repeat (n) @(posedge link_clk); // stretch only as long as a test asks
  endtask

  // data falls while clock is high, then clock goes low
  task automatic start_cond();
    lines(1'h1, 1'h0, 3);
    lines(1'h0, 1'h0, 3);
  endtask

  // data rises while clock is high
  task automatic stop_cond();
    lines(1'h0, 1'h0, 3);
    lines(1'h1, 1'h0, 3);
    lines(1'h1, 1'h1, 3); // both released, bus goes idle
  endtask
endmodule

// ==== smb_line_sampler.sv ====
`timescale 1ns/1ps
module smb_line_sampler
  import smb_pkg::*;
(
  // link clock and reset
  input wire logic link_clk,
  input wire logic rst,
  // bus pins
  input wire logic bus_clock_line,
  input wire logic bus_data_line,
  // sampled levels and condition toggles
  output logic scl_lvl_q,
  output logic sda_lvl_q,
  output logic start_tgl_q,
  output logic stop_tgl_q
);

  // ---------------------------------------------------------------
  // reset and pin synchronisers in the link domain
  // ---------------------------------------------------------------
  logic [1:0] rst_l_q;
  logic scl_m_q;
  logic sda_m_q;
  logic scl_p_q;
  logic sda_p_q;
  logic start_det;
  logic stop_det;

  // reset brought over into the link domain
  always_ff @(posedge link_clk) begin
    rst_l_q <= {rst_l_q[0], rst};
  end

  // two flops on each pin, then one history flop
  always_ff @(posedge link_clk) begin
    if (rst_l_q[1]) begin
      scl_m_q <= LINE_RST;
      sda_m_q <= LINE_RST;
      scl_lvl_q <= LINE_RST;
      sda_lvl_q <= LINE_RST;
      scl_p_q <= LINE_RST;
      sda_p_q <= LINE_RST;
    end else begin
      scl_m_q <= bus_clock_line;
      sda_m_q <= bus_data_line;
      scl_lvl_q <= scl_m_q;
      sda_lvl_q <= sda_m_q;
      scl_p_q <= scl_lvl_q;
      sda_p_q <= sda_lvl_q;
    end
  end

  // ---------------------------------------------------------------
  // start and stop detection, sent across as toggles
  // ---------------------------------------------------------------
  assign start_det = scl_lvl_q && scl_p_q && sda_p_q && !sda_lvl_q;
  assign stop_det = scl_lvl_q && scl_p_q && !sda_p_q && sda_lvl_q;

  // each condition flips its toggle once
  always_ff @(posedge link_clk) begin
    if (rst_l_q[1]) begin
      start_tgl_q <= 1'h0;
      stop_tgl_q <= 1'h0;
    end else begin
      start_tgl_q <= start_tgl_q ^ start_det;
      stop_tgl_q <= stop_tgl_q ^ stop_det;
    end
  end

endmodule

// ==== smb_pkg.sv ====
package smb_pkg;

  // ---------------------------------------------------------------
  // clock rate
  // ---------------------------------------------------------------
  localparam int unsigned CORE_CLK_KHZ = 200000;

  // ---------------------------------------------------------------
  // bus timing limits, as printed, and their cycle counts
  // ---------------------------------------------------------------
  localparam int unsigned CLK_LOW_TIMEOUT_MS = 35;
  localparam int unsigned IDLE_RESET_MS = 50;
  localparam int unsigned IDLE_HIGH_US = 50;
  // longest times: round down
  localparam int unsigned CLK_LOW_TIMEOUT_CYC = CLK_LOW_TIMEOUT_MS * CORE_CLK_KHZ;
  localparam int unsigned IDLE_RESET_CYC = IDLE_RESET_MS * CORE_CLK_KHZ;
  localparam int unsigned IDLE_HIGH_CYC = (IDLE_HIGH_US * CORE_CLK_KHZ) / 1000;

  // ---------------------------------------------------------------
  // counter width and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
  localparam logic LINE_RST = 1'h1;
  localparam int unsigned SYNC_W = 4;
  localparam logic [SYNC_W-1:0] SYNC_RST = 4'h3;

  // ---------------------------------------------------------------
  // protocol tracking state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SMB_IDLE    = 3'h1,
    SMB_BUSY    = 3'h2,
    SMB_ABANDON = 3'h4
  } smb_state_e;

endpackage

// ==== smb_timeout_monitor.sv ====
`timescale 1ns/1ps
module smb_timeout_monitor
  import smb_pkg::*;
#(
  parameter logic [CNT_W-1:0] LOW_TIMEOUT_CYC = CNT_W'(CLK_LOW_TIMEOUT_CYC),
  parameter logic [CNT_W-1:0] IDLE_RST_CYC = CNT_W'(IDLE_RESET_CYC),
  parameter logic [CNT_W-1:0] IDLE_HI_CYC = CNT_W'(IDLE_HIGH_CYC)
)
(
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // link clock
  input wire logic link_clk,
  // bus pins
  input wire logic bus_clock_line,
  input wire logic bus_data_line,
  output logic scl_out_q,
  output logic scl_oe_q,
  output logic sda_out_q,
  output logic sda_oe_q,
  // protocol engine side
  input wire logic scl_pull_req,
  input wire logic sda_pull_req,
  input wire logic nonconforming_bus_select,
  // status
  output logic timeout_err_q,
  output logic idle_reset_q,
  output logic bus_idle_q,
  output logic busy_q
);

  // ---------------------------------------------------------------
  // link side sampling
  // ---------------------------------------------------------------
  logic scl_lvl;
  logic sda_lvl;
  logic start_tgl;
  logic stop_tgl;

  smb_line_sampler u_sampler (
    .link_clk(link_clk),
    .rst(rst),
    .bus_clock_line(bus_clock_line),
    .bus_data_line(bus_data_line),
    .scl_lvl_q(scl_lvl),
    .sda_lvl_q(sda_lvl),
    .start_tgl_q(start_tgl),
    .stop_tgl_q(stop_tgl)
  );

  // ---------------------------------------------------------------
  // crossing into the core domain
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] x1_q;
  logic [SYNC_W-1:0] x2_q;
  logic [1:0] tgl_p_q;
  logic scl_hi;
  logic both_hi;
  logic start_ev;
  logic stop_ev;

  // two flops per crossing bit; the first is read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (rst) begin
          x1_q[gi] <= SYNC_RST[gi];
          x2_q[gi] <= SYNC_RST[gi];
        end else begin
          x1_q[gi] <= (gi == 0) ? scl_lvl : (gi == 1) ? sda_lvl :
                      (gi == 2) ? start_tgl : stop_tgl;
          x2_q[gi] <= x1_q[gi];
        end
      end
    end
  endgenerate

  // toggle history for event pulses
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tgl_p_q <= 2'h0;
    end else begin
      tgl_p_q <= x2_q[3:2];
    end
  end

  assign scl_hi = x2_q[0];
  assign both_hi = x2_q[0] && x2_q[1];
  assign start_ev = x2_q[2] ^ tgl_p_q[0];
  assign stop_ev = x2_q[3] ^ tgl_p_q[1];

  // ---------------------------------------------------------------
  // interval counters
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] low_cnt_q;
  logic [CNT_W-1:0] both_cnt_q;
  logic [CNT_W-1:0] hi_cnt_q;
  logic low_expire;
  logic both_expire;

  // saturating counter step
  function automatic logic [CNT_W-1:0] cnt_step(input logic run,
                                                input logic [CNT_W-1:0] cur,
                                                input logic [CNT_W-1:0] lim);
    cnt_step = !run ? CNT_RST : (cur == lim) ? lim : cur + CNT_W'(1);
  endfunction

  // limits are times in core cycles, independent of bus rate
  always_ff @(posedge core_clk) begin
    if (rst) begin
      low_cnt_q <= CNT_RST;
      both_cnt_q <= CNT_RST;
      hi_cnt_q <= CNT_RST;
    end else begin
      low_cnt_q <= cnt_step(!scl_hi, low_cnt_q, LOW_TIMEOUT_CYC);
      both_cnt_q <= cnt_step(both_hi, both_cnt_q, IDLE_RST_CYC);
      hi_cnt_q <= cnt_step(scl_hi, hi_cnt_q, IDLE_HI_CYC);
    end
  end

  // expiry fires once as the low and both-high counters reach their limits
  assign low_expire = !scl_hi && (low_cnt_q == LOW_TIMEOUT_CYC - CNT_W'(1))
                      && !nonconforming_bus_select;
  assign both_expire = both_hi && (both_cnt_q == IDLE_RST_CYC - CNT_W'(1))
                       && !nonconforming_bus_select;

  // ---------------------------------------------------------------
  // protocol state
  // ---------------------------------------------------------------
  smb_state_e state_q;

  // timeout takes priority, then idle reset, then stop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= SMB_IDLE;
    end else begin
      case (state_q)
        SMB_IDLE: begin
          if (low_expire) begin
            state_q <= SMB_ABANDON;
          end else if (start_ev) begin
            state_q <= SMB_BUSY;
          end
        end
        SMB_BUSY: begin
          if (low_expire) begin
            state_q <= SMB_ABANDON;
          end else if (both_expire || stop_ev) begin
            state_q <= SMB_IDLE;
          end
        end
        SMB_ABANDON: begin
          if (start_ev) begin
            state_q <= SMB_BUSY;
          end
        end
        default: begin
          state_q <= SMB_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      timeout_err_q <= 1'h0;
      idle_reset_q <= 1'h0;
      bus_idle_q <= 1'h0;
      busy_q <= 1'h0;
    end else begin
      timeout_err_q <= low_expire;
      idle_reset_q <= both_expire && (state_q == SMB_BUSY);
      bus_idle_q <= scl_hi && (hi_cnt_q == IDLE_HI_CYC);
      busy_q <= (state_q == SMB_BUSY);
    end
  end

  // ---------------------------------------------------------------
  // pin drive: lines released while abandoned or just reset
  // ---------------------------------------------------------------
  logic release_now;

  assign release_now = (state_q == SMB_ABANDON) || low_expire || both_expire;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_out_q <= 1'h0;
      sda_out_q <= 1'h0;
      scl_oe_q <= 1'h0;
      sda_oe_q <= 1'h0;
    end else begin
      scl_out_q <= 1'h0;
      sda_out_q <= 1'h0;
      scl_oe_q <= scl_pull_req && !release_now;
      sda_oe_q <= sda_pull_req && !release_now;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_low_expiry;
    !scl_hi && !nonconforming_bus_select && low_cnt_q == LOW_TIMEOUT_CYC - CNT_W'(1);
  endsequence

  sequence s_abandoned;
    state_q == SMB_ABANDON;
  endsequence

  a_timeout_flag: assert property (@(posedge core_clk) disable iff (rst)
    s_low_expiry |=> timeout_err_q ##0 s_abandoned)
    else $error("clock low limit passed without timeout and abandon");

  a_timeout_cause: assert property (@(posedge core_clk) disable iff (rst)
    timeout_err_q |-> !$past(nonconforming_bus_select) && !$past(scl_hi))
    else $error("timeout raised without a low clock or with select set");

  a_timeout_once: assert property (@(posedge core_clk) disable iff (rst)
    timeout_err_q |=> !timeout_err_q)
    else $error("timeout flag held longer than one cycle");

  a_idle_reset: assert property (@(posedge core_clk) disable iff (rst)
    (both_expire && state_q == SMB_BUSY) |=> idle_reset_q && state_q == SMB_IDLE)
    else $error("long high period did not reset the transaction");

  a_bus_idle: assert property (@(posedge core_clk) disable iff (rst)
    bus_idle_q |-> $past(hi_cnt_q) == IDLE_HI_CYC && $past(scl_hi))
    else $error("bus idle shown before the high limit");

  a_release_lines: assert property (@(posedge core_clk) disable iff (rst)
    s_abandoned ##1 s_abandoned |-> !scl_oe_q && !sda_oe_q)
    else $error("line driven while the transfer is abandoned");

  a_start_resume: assert property (@(posedge core_clk) disable iff (rst)
    s_abandoned ##0 start_ev |=> state_q == SMB_BUSY)
    else $error("start did not resume after abandon");

  a_nc_quiet: assert property (@(posedge core_clk) disable iff (rst)
    nonconforming_bus_select [*2] |-> !timeout_err_q && !idle_reset_q)
    else $error("limit acted while nonconforming select set");

  a_low_reach: assert property (@(posedge core_clk) disable iff (rst)
    scl_hi |=> low_cnt_q == CNT_RST)
    else $error("low counter not cleared by high clock");

endmodule

// ==== test_smb_timeout_monitor.sv ====
`timescale 1ns/1ps
module test_smb_timeout_monitor;
  import smb_pkg::*;
  // ---------------------------------------------------------------
  // shortened limits and signals
  // ---------------------------------------------------------------
  localparam logic [CNT_W-1:0] LOW_CYC = 24'h0000C8;
  localparam logic [CNT_W-1:0] IDLE_RST = 24'h00012C;
  localparam logic [CNT_W-1:0] IDLE_HI = 24'h000032;
  logic core_clk = 1'h0;
  logic link_clk = 1'h0;
  logic rst = 1'h1;
  logic scl_pull_req = 1'h0;
  logic sda_pull_req = 1'h0;
  logic ncs = 1'h0;
  wire bus_clock_line, bus_data_line, scl_out_q, scl_oe_q, sda_out_q, sda_oe_q;
  wire timeout_err_q, idle_reset_q, bus_idle_q, busy_q;
  int err_total = 0;
  int n_tests = 0;
  int seen_to = 0;
  int seen_ir = 0;
  // rows: scl req, sda req, expected scl oe, expected sda oe
  logic [3:0] rows [5] = '{4'h0, 4'hA, 4'hF, 4'h5, 4'h0};

  smb_timeout_monitor #(
    .LOW_TIMEOUT_CYC(LOW_CYC),
    .IDLE_RST_CYC(IDLE_RST),
    .IDLE_HI_CYC(IDLE_HI)
  ) smb_timeout_monitor_inst (
    .core_clk(core_clk), .rst(rst), .link_clk(link_clk),
    .bus_clock_line(bus_clock_line), .bus_data_line(bus_data_line),
    .scl_out_q(scl_out_q), .scl_oe_q(scl_oe_q), .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q),
    .scl_pull_req(scl_pull_req), .sda_pull_req(sda_pull_req),
    .nonconforming_bus_select(ncs),
    .timeout_err_q(timeout_err_q), .idle_reset_q(idle_reset_q),
    .bus_idle_q(bus_idle_q), .busy_q(busy_q)
  );
  smb_far_agent smb_far_agent_inst (
    .link_clk(link_clk), .scl_oe(scl_oe_q), .sda_oe(sda_oe_q),
    .bus_clock_line(bus_clock_line), .bus_data_line(bus_data_line)
  );

  // ---------------------------------------------------------------
  // clocks, checks and ending
  // ---------------------------------------------------------------
  // core clock 5 ns, link clock 32 ns with an unrelated phase
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #7.3;
    forever #16 link_clk = ~link_clk;
  end

  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  // count status pulses over n core cycles
  task automatic watch(input int n);
    seen_to = 0;
    seen_ir = 0;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (timeout_err_q === 1'h1) seen_to++;
      if (idle_reset_q === 1'h1) seen_ir++;
    end
  endtask

  task automatic close_out();
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog far beyond the expected run of about 12 us
  initial begin
    #100000;
    err_total++;
    close_out();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    // held long enough for the link side to see reset too
    repeat (30) @(posedge core_clk);
    rst <= 1'h0;
    watch(1);
    check({timeout_err_q, idle_reset_q, busy_q, scl_oe_q}, 4'h0);
    check({sda_oe_q, scl_out_q, sda_out_q, 1'h0}, 4'h0);
    watch(100);
    check({3'h0, bus_idle_q}, 4'h1);
    for (int i = 0; i < 5; i++) begin
      @(posedge core_clk);
      scl_pull_req <= rows[i][3];
      sda_pull_req <= rows[i][2];
      watch(3);
      check({2'h0, scl_oe_q, sda_oe_q}, {2'h0, rows[i][1:0]});
    end
    watch(40);
    // plain start and stop
    smb_far_agent_inst.start_cond();
    watch(40);
    check({2'h0, busy_q, bus_idle_q}, 4'h2);
    smb_far_agent_inst.stop_cond();
    watch(40);
    check({3'h0, busy_q}, 4'h0);
    // clock held low past the limit while the device pulls data
    smb_far_agent_inst.start_cond();
    @(posedge core_clk);
    sda_pull_req <= 1'h1;
    fork
      smb_far_agent_inst.lines(1'h0, 1'h1, 40);
      watch(300);
    join
    check(4'(seen_to), 4'h1);
    check({2'h0, sda_oe_q, busy_q}, 4'h0);
    smb_far_agent_inst.lines(1'h1, 1'h1, 3);
    watch(40);
    check({3'h0, sda_oe_q}, 4'h0);
    @(posedge core_clk);
    sda_pull_req <= 1'h0;
    // a new start lifts the refusal
    smb_far_agent_inst.start_cond();
    @(posedge core_clk);
    sda_pull_req <= 1'h1;
    watch(3);
    check({2'h0, sda_oe_q, busy_q}, 4'h3);
    @(posedge core_clk);
    sda_pull_req <= 1'h0;
    // both lines high without a stop
    smb_far_agent_inst.lines(1'h0, 1'h1, 3);
    smb_far_agent_inst.lines(1'h1, 1'h1, 3);
    watch(400);
    check(4'(seen_ir), 4'h1);
    check({2'h0, busy_q, bus_idle_q}, 4'h1);
    // nonconforming select: no limit action at all
    @(posedge core_clk);
    ncs <= 1'h1;
    smb_far_agent_inst.start_cond();
    fork
      smb_far_agent_inst.lines(1'h0, 1'h1, 40);
      watch(300);
    join
    check({4'(seen_to)} | {3'h0, ~busy_q}, 4'h0);
    smb_far_agent_inst.lines(1'h1, 1'h1, 3);
    watch(400);
    check({4'(seen_ir)} | {3'h0, ~busy_q}, 4'h0);
    smb_far_agent_inst.stop_cond();
    @(posedge core_clk);
    ncs <= 1'h0;
    watch(40);
    check({3'h0, busy_q}, 4'h0);
    // reset in mid transfer: outputs back to rest, no false event after
    smb_far_agent_inst.start_cond();
    @(posedge core_clk);
    sda_pull_req <= 1'h1;
    watch(3);
    check({2'h0, sda_oe_q, busy_q}, 4'h3);
    @(posedge core_clk);
    rst <= 1'h1;
    sda_pull_req <= 1'h0;
    repeat (30) @(posedge core_clk);
    rst <= 1'h0;
    watch(1);
    check({timeout_err_q, idle_reset_q, busy_q, scl_oe_q}, 4'h0);
    check({sda_oe_q, scl_out_q, sda_out_q, 1'h0}, 4'h0);
    watch(40);
    check({2'h0, busy_q, bus_idle_q}, 4'h0);
    close_out();
  end
endmodule
